// File: design/dma_chan_pkg.sv
// constants and types shared by the dma channel control block
package dma_chan_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;

  // channel_control field positions
  localparam int BUSY_BIT = 15;
  localparam int DIR_BIT = 8;
  localparam int ON_BIT = 7;
  localparam int EWO_BIT = 6;
  localparam int CHAIN_BIT = 5;
  localparam int AUTO_BIT = 4;
  localparam int SEEN_BIT = 2;
  localparam int PRIO_LSB = 0;
  localparam int PRIO_W = 2;

  // interrupt event positions
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_START = 1;
  localparam int EV_ABORT = 2;
  localparam int EV_CHAIN = 3;

  // reset values
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam logic [31:0] RD_RST = 32'h0000_0000;

  // software-writable control fields
  typedef struct packed {
    logic dir;
    logic on;
    logic ewo;
    logic chain;
    logic auto_en;
    logic [PRIO_W-1:0] prio;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0};

  // request state of the channel
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PEND,
    ST_DRAIN
  } chan_st_t;

endpackage : dma_chan_pkg

// File: design/dma_irq_regs.sv
// sticky event status, mask and level interrupt for one channel
module dma_irq_regs
  import dma_chan_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [EV_W-1:0] ev_i,
  input wire logic wr_stat_i,
  input wire logic wr_mask_i,
  input wire logic [EV_W-1:0] wdata_i,
  output logic [EV_W-1:0] status_o,
  output logic [EV_W-1:0] mask_o,
  output logic irq_o
);

  logic [EV_W-1:0] stat_r;
  logic [EV_W-1:0] stat_nxt;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] mask_nxt;

  // write-one-to-clear; a new event in the clear cycle wins
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (wr_stat_i) begin
      stat_nxt = stat_r & ~wdata_i;
    end
    stat_nxt = stat_nxt | ev_i;
    if (wr_mask_i) begin
      mask_nxt = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stat_r <= EV_RST;
      mask_r <= EV_RST;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign status_o = stat_r;
  assign mask_o = mask_r;
  assign irq_o = |(stat_r & mask_r);

endmodule : dma_irq_regs

// File: design/dma_channel_control.sv
// control and status logic of one dma channel with register port
//
// Behaviour
// RL1 - busy reads high while the channel is on or active, low once off and idle.
// RL2 - with direction set, lower-priority neighbour completion enables us; else the higher one.
// RL3 - the direction bit only matters while chaining is allowed.
// RL4 - channel_on one means enabled, zero means disabled.
// RL5 - with events_when_off set, start/abort events count while disabled; otherwise ignored.
// RL6 - chaining can enable the channel only while chain_allow is set.
// RL7 - block completion clears channel_on unless auto re-enable is set.
// RL8 - the read-only event seen flag shows a detected event, zero otherwise.
// RL9 - the two-bit priority maps 11 to highest level 3 and 00 to lowest level 0.
// RL10 - clearing channel_on lets the running transaction finish; software polls busy.
// RL11 - unimplemented control bits, the upper half, bits 14..9 and bit 3, read as zero.
// RL12 - reset clears every control and status field: channel off and idle.
//
// all inputs are on clk_i; nothing is synchronised here
// reset is synchronous and active low
// single-cycle register reads, no wait state
//
// register map, byte offsets
// 0x00 channel_control, 0x04 event status, 0x08 event mask
//
// channel_control layout
// 31..16 read zero
// 15 channel_active_flag, read only
// 14..9 read zero
// 8 chain_direction_select
// 7 channel_on
// 6 events_when_off
// 5 chain_allow
// 4 auto_reenable
// 3 reads zero
// 2 event_seen_flag, read only
// 1..0 channel_priority
//
// event status and mask layout
// 0 block transfer complete
// 1 start accepted
// 2 abort accepted
// 3 enabled by chaining
//
// precedence on channel_on within one cycle
// chaining set beats any clear
// abort or block end clear beats a software write
//
// limitations
// rdata_o is zero outside the cycle after a read strobe
// busy and seen bits ignore writes, both are status only
// xfer_req_o may still be high in the block end cycle,
// so the datapath must not start a beat on that edge
//
// The implementer's own choices: the plain strobed port and the register addresses.
module dma_channel_control
  import dma_chan_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // neighbour channels and trigger sources
  input wire logic lower_done_i,
  input wire logic higher_done_i,
  input wire logic start_evt_i,
  input wire logic abort_evt_i,
  // transfer datapath
  input wire logic xact_busy_i,
  input wire logic xact_done_i,
  input wire logic block_done_i,
  output logic xfer_req_o,
  output logic channel_on_o,
  output logic busy_o,
  output logic [PRIO_W-1:0] priority_o,
  output logic done_o,
  output logic irq_o
);

  // control register state
  ctrl_t ctrl_r;
  ctrl_t ctrl_nxt;
  logic seen_r;
  logic seen_nxt;
  logic busy_r;
  logic busy_nxt;

  // request state
  chan_st_t st_r;
  chan_st_t st_nxt;
  logic done_r;
  logic done_nxt;

  // read port
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // decoded accesses and events
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic ev_ok;
  logic start_ok;
  logic abort_ok;
  logic chain_hit;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] stat;
  logic [EV_W-1:0] mask;

  // address decode of write strobe
  // unmapped offsets decode to nothing and are ignored
  assign wr_ctrl = wr_i && (addr_i == CTRL_OFS);
  assign wr_stat = wr_i && (addr_i == STAT_OFS);
  assign wr_mask = wr_i && (addr_i == MASK_OFS);

  // events pass while on, or while off if allowed
  // a refused event leaves no status bit and no seen mark
  assign ev_ok = ctrl_r.on || ctrl_r.ewo; // [RL5]
  assign start_ok = start_evt_i && ev_ok; // [RL5]
  assign abort_ok = abort_evt_i && ev_ok; // [RL5]

  // neighbour completion picked by direction, gated by chain allow
  // both neighbour pulses are ignored while chaining is off
  assign chain_hit = ctrl_r.chain && (ctrl_r.dir ? lower_done_i : higher_done_i); // [RL2] [RL3] [RL6]

  // control fields: software writes, chaining sets, completion clears
  always_comb begin
    ctrl_nxt = ctrl_r;
    // software write of every writable field
    if (wr_ctrl) begin
      ctrl_nxt.dir = wdata_i[DIR_BIT];
      ctrl_nxt.on = wdata_i[ON_BIT]; // [RL4]
      ctrl_nxt.ewo = wdata_i[EWO_BIT];
      ctrl_nxt.chain = wdata_i[CHAIN_BIT];
      ctrl_nxt.auto_en = wdata_i[AUTO_BIT];
      ctrl_nxt.prio = wdata_i[PRIO_LSB +: PRIO_W]; // [RL9]
    end
    // hardware clears take effect after a software write in the same cycle
    if (block_done_i && !ctrl_r.auto_en) begin
      ctrl_nxt.on = 1'b0; // [RL7]
    end
    if (abort_ok) begin
      ctrl_nxt.on = 1'b0;
    end
    // chaining enable wins over any clear
    if (chain_hit) begin
      ctrl_nxt.on = 1'b1; // [RL6]
    end
  end

  // event seen flag: set wins over completion clear
  always_comb begin
    seen_nxt = seen_r;
    // block end or abort clears the mark
    if (block_done_i || abort_ok) begin
      seen_nxt = 1'b0;
    end
    // accepted start marks the event
    if (start_ok) begin
      seen_nxt = 1'b1; // [RL8]
    end
  end

  // busy follows the enable, and holds while a transaction drains
  // registered so a read of bit 15 matches busy_o
  always_comb begin
    busy_nxt = ctrl_nxt.on || xact_busy_i; // [RL1] [RL10]
  end

  // control state registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST; // [RL12]
      seen_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      seen_r <= seen_nxt;
      busy_r <= busy_nxt;
    end
  end

  // request sequencing: a start waits for enable, a cleared
  // enable stops new requests but the datapath finishes its beat
  always_comb begin
    st_nxt = st_r;
    done_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        // a refused start never leaves idle
        if (start_ok) begin
          st_nxt = ST_PEND;
        end
      end
      ST_PEND: begin
        // abort drops the pending request at once
        if (abort_ok) begin
          st_nxt = ST_IDLE;
        end else if (!ctrl_r.on && xact_busy_i) begin
          st_nxt = ST_DRAIN; // [RL10]
        end else if (block_done_i) begin
          st_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      ST_DRAIN: begin
        // suspended: back to pending once the datapath transaction ends
        // abort still wins while suspended
        if (abort_ok) begin
          st_nxt = ST_IDLE;
        end else if (xact_done_i || !xact_busy_i) begin
          st_nxt = ST_PEND; // [RL10]
        end
      end
      default: begin
        // unused encoding falls back to idle
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // request state registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE; // [RL12]
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      done_r <= done_nxt;
    end
  end

  // new transactions only while enabled and not draining
  // combinational so the datapath sees the stop at once
  assign xfer_req_o = (st_r == ST_PEND) && ctrl_r.on; // [RL4] [RL10]

  // interrupt events
  // chaining also raises its own event bit
  assign ev[EV_DONE] = block_done_i;
  assign ev[EV_START] = start_ok;
  assign ev[EV_ABORT] = abort_ok;
  assign ev[EV_CHAIN] = chain_hit;

  // sticky status, mask and level interrupt
  dma_irq_regs u_irq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ev_i(ev),
    .wr_stat_i(wr_stat),
    .wr_mask_i(wr_mask),
    .wdata_i(wdata_i[EV_W-1:0]),
    .status_o(stat),
    .mask_o(mask),
    .irq_o(irq_o)
  );

  // read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = RD_RST; // [RL11]
    if (rd_i) begin
      case (addr_i)
        CTRL_OFS: begin
          rdata_nxt[BUSY_BIT] = busy_r; // [RL1]
          rdata_nxt[DIR_BIT] = ctrl_r.dir;
          rdata_nxt[ON_BIT] = ctrl_r.on;
          rdata_nxt[EWO_BIT] = ctrl_r.ewo;
          rdata_nxt[CHAIN_BIT] = ctrl_r.chain;
          rdata_nxt[AUTO_BIT] = ctrl_r.auto_en;
          rdata_nxt[SEEN_BIT] = seen_r; // [RL8]
          rdata_nxt[PRIO_LSB +: PRIO_W] = ctrl_r.prio;
        end
        // status words fill only the low event bits
        STAT_OFS: begin
          rdata_nxt[EV_W-1:0] = stat;
        end
        MASK_OFS: begin
          rdata_nxt[EV_W-1:0] = mask;
        end
        default: begin
          // unmapped offsets read as zero
          rdata_nxt = RD_RST;
        end
      endcase
    end
  end

  // read data register, zero when no read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= RD_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = rdata_r;
  assign channel_on_o = ctrl_r.on;
  assign busy_o = busy_r;
  assign priority_o = ctrl_r.prio; // [RL9]
  assign done_o = done_r;

endmodule : dma_channel_control

// File: test/dma_channel_control_sva.sv
// port assertions for the dma channel control block
module dma_channel_control_sva
  import dma_chan_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic lower_done_i,
  input wire logic higher_done_i,
  input wire logic start_evt_i,
  input wire logic abort_evt_i,
  input wire logic xact_busy_i,
  input wire logic xact_done_i,
  input wire logic block_done_i,
  input wire logic xfer_req_o,
  input wire logic channel_on_o,
  input wire logic busy_o,
  input wire logic [PRIO_W-1:0] priority_o,
  input wire logic done_o,
  input wire logic irq_o
);
  logic [8:0] sh_r;
  logic hit;
  // shadow of software-only control bits; hardware never alters them
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      sh_r <= 9'h000;
    else if (wr_i && addr_i == CTRL_OFS)
      sh_r <= wdata_i[8:0];
  end
  assign hit = sh_r[CHAIN_BIT] && (sh_r[DIR_BIT] ? lower_done_i : higher_done_i);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RST_CLR: assert property (disable iff (1'b0) !rst_n_i |=> !channel_on_o && !busy_o && !irq_o)
    else $error("outputs not cleared by reset");
  AST_BUSY: assert property ($past(rst_n_i) |-> busy_o == (channel_on_o || $past(xact_busy_i)))
    else $error("busy flag wrong");
  AST_CHAIN_ON: assert property (hit |=> channel_on_o)
    else $error("chain did not enable");
  AST_STAY_OFF: assert property (!channel_on_o && !wr_i && !hit |=> !channel_on_o)
    else $error("channel enabled without cause");
  AST_AUTO_OFF: assert property (block_done_i && channel_on_o && !sh_r[AUTO_BIT] && !wr_i && !hit |=> !channel_on_o)
    else $error("block end left channel on");
  AST_AUTO_KEEP: assert property (block_done_i && channel_on_o && sh_r[AUTO_BIT] && !abort_evt_i && !wr_i |=> channel_on_o)
    else $error("auto mode lost channel");
  AST_RD_ZERO: assert property (rd_i |=> rdata_o[31:16] == 16'h0000 && rdata_o[14:9] == 6'h00 && !rdata_o[3])
    else $error("unimplemented bits not zero");
  AST_PRIO: assert property (wr_i && addr_i == CTRL_OFS |=> priority_o == $past(wdata_i[1:0]))
    else $error("priority not taken");
  AST_RD_ON: assert property (rd_i && addr_i == CTRL_OFS |=> rdata_o[ON_BIT] == $past(channel_on_o) && rdata_o[BUSY_BIT] == $past(busy_o))
    else $error("control read wrong");
  AST_REQ_OFF: assert property (!channel_on_o |-> !xfer_req_o)
    else $error("request while channel off");
  // main scenarios
  cover property (hit);
  cover property (block_done_i && sh_r[AUTO_BIT]);
  cover property (busy_o && !channel_on_o);
endmodule : dma_channel_control_sva

bind dma_channel_control dma_channel_control_sva u_sva (.*);

// File: test/dma_far_model.sv
// datapath model: runs transactions while requested, reports block end
module dma_far_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic xfer_req_i,
  input wire logic slow_i,
  output logic xact_busy_o,
  output logic xact_done_o,
  output logic block_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  logic blk_r;
  // two transactions make a block; slow mode stretches each one
  always @(posedge clk_i) begin
    xact_done_o <= 1'b0;
    block_done_o <= 1'b0;
    if (!rst_n_i) begin
      cnt_r <= 3'h0;
      blk_r <= 1'b0;
      xact_busy_o <= 1'b0;
    end else if (xact_busy_o) begin
      cnt_r <= cnt_r - 3'h1;
      if (cnt_r == 3'h0) begin
        xact_busy_o <= 1'b0;
        xact_done_o <= 1'b1;
        blk_r <= ~blk_r;
        block_done_o <= blk_r;
      end
    end else if (xfer_req_i) begin
      xact_busy_o <= 1'b1;
      cnt_r <= slow_i ? 3'h6 : 3'h1;
    end
  end
endmodule : dma_far_model

// File: test/testbench.sv
// self-checking bench for the dma channel control block
module testbench;
  import dma_chan_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] w; logic [31:0] r;} row_t;
  row_t rows[5] = '{'{32'h0, 32'h0}, '{32'h1, 32'h1}, '{32'h2, 32'h2}, '{32'h3, 32'h3}, '{32'hFFFF_FF7F, 32'h173}};
  logic [8:0] cc[6] = '{9'h020, 9'h020, 9'h120, 9'h120, 9'h000, 9'h100};
  logic [3:0] ce[6] = '{4'h8, 4'h4, 4'h8, 4'h4, 4'h4, 4'h8};
  logic co[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] ev = 4'h0; // lower, higher, start, abort
  logic slow = 1'b0;
  logic [31:0] rdata_o, d;
  logic xfer_req_o, channel_on_o, busy_o, done_o, irq_o, xb, xd, bd;
  logic [1:0] priority_o;
  int fails = 0;
  int check_count = 0;
  dma_channel_control u_dma_channel_control (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lower_done_i(ev[3]),
    .higher_done_i(ev[2]), .start_evt_i(ev[1]), .abort_evt_i(ev[0]), .xact_busy_i(xb), .xact_done_i(xd),
    .block_done_i(bd), .xfer_req_o(xfer_req_o), .channel_on_o(channel_on_o), .busy_o(busy_o),
    .priority_o(priority_o), .done_o(done_o), .irq_o(irq_o));
  dma_far_model u_dma_far_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .xfer_req_i(xfer_req_o), .slow_i(slow),
    .xact_busy_o(xb), .xact_done_o(xd), .block_done_o(bd));
  initial forever #5 clk_i = ~clk_i;
  task final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // every bus task leaves 1 ns after its last edge so outputs have settled
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task pulse(input logic [3:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 4'h0;
    #1;
  endtask : pulse
  // bounded wait: 0 channel_on, 1 busy, 2 done, 3 datapath busy
  task wt(input int k, input logic v);
    int i;
    for (i = 0; i < 50; i++) begin
      if ((k == 0 ? channel_on_o : k == 1 ? busy_o : k == 2 ? done_o : xb) === v) break;
      @(posedge clk_i);
      #1;
    end
    chk("wait", 32'h0, (i == 50) ? 32'h1 : 32'h0);
    if (i == 50) final_report();
  endtask : wt
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(CTRL_OFS);
    chk("ctrl reset", 32'h0, d);
    foreach (rows[i]) begin
      wr(CTRL_OFS, rows[i].w);
      chk("prio", {30'h0, rows[i].r[1:0]}, {30'h0, priority_o});
      rd(CTRL_OFS);
      chk("ctrl", rows[i].r, d);
    end
    wr(CTRL_OFS, 32'h0000_0080);
    chk("busy", 32'h1, {31'h0, busy_o});
    pulse(4'h2);
    rd(CTRL_OFS);
    chk("seen", 32'h0000_8084, d);
    wt(0, 1'b0);
    wt(1, 1'b0);
    wr(CTRL_OFS, 32'h0000_0090);
    pulse(4'h2);
    wt(2, 1'b1);
    chk("auto on", 32'h1, {31'h0, channel_on_o});
    pulse(4'h1);
    for (int i = 0; i < 6; i++) begin
      wr(CTRL_OFS, {23'h0, cc[i]});
      pulse(ce[i]);
      chk("chain", {31'h0, co[i]}, {31'h0, channel_on_o});
    end
    wr(CTRL_OFS, 32'h0);
    wr(MASK_OFS, 32'h0000_0006);
    wr(STAT_OFS, 32'h0000_000F);
    pulse(4'h2);
    rd(CTRL_OFS);
    chk("seen off", 32'h0, d);
    chk("irq off", 32'h0, {31'h0, irq_o});
    wr(CTRL_OFS, 32'h0000_0040);
    pulse(4'h2);
    rd(CTRL_OFS);
    chk("seen ewo", 32'h0000_0044, d);
    pulse(4'h1);
    rd(STAT_OFS);
    chk("status", 32'h0000_0006, d);
    chk("irq on", 32'h1, {31'h0, irq_o});
    wr(STAT_OFS, 32'h0000_0006);
    rd(8'h0C);
    chk("unmapped", 32'h0, d);
    chk("irq clr", 32'h0, {31'h0, irq_o});
    @(posedge clk_i) slow <= 1'b1;
    wr(CTRL_OFS, 32'h0000_0080);
    pulse(4'h2);
    wt(3, 1'b1);
    chk("req on", 32'h1, {31'h0, xfer_req_o});
    wr(CTRL_OFS, 32'h0);
    chk("drain", 32'h1, {31'h0, busy_o});
    chk("req off", 32'h0, {31'h0, xfer_req_o});
    wt(1, 1'b0);
    // reset in mid-run with every field set and a transfer starting
    wr(CTRL_OFS, 32'h0000_01F3);
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(CTRL_OFS);
    chk("mid reset", 32'h0, d);
    chk("mid reset on", 32'h0, {31'h0, channel_on_o});
    final_report();
  end
endmodule : testbench
